// ---- design/bcs_pkg.sv ----
/*
 * constants for the bridge command/status bit bank: offsets, field positions, reset values
 * assumes a 12-bit configuration address and 32-bit dword configuration accesses
 */
`default_nettype none
package bcs_pkg;
   localparam int CFG_ADDR_W = 12;
   localparam int CFG_DATA_W = 32;
   localparam int CFG_BE_W = 4;
   localparam int REG_W = 16;
   // printed byte offsets
   localparam logic [CFG_ADDR_W-1:0] BRIDGE_COMMAND_OFS = 12'h004;
   localparam logic [CFG_ADDR_W-1:0] BRIDGE_STATUS_OFS = 12'h006;
   localparam logic [CFG_ADDR_W-1:0] DWORD_MASK = 12'hffc;
   // byte lanes of the dword at the command offset
   localparam int LANE_CMD_LO = 0;
   localparam int LANE_CMD_HI = 1;
   localparam int LANE_STS_LO = 2;
   localparam int LANE_STS_HI = 3;
   // command fields
   localparam int CMD_PERR_EN_BIT = 6;
   localparam int CMD_SERR_EN_BIT = 8;
   localparam int CMD_B2B_EN_BIT = 9;
   localparam int CMD_IRQ_DIS_BIT = 10;
   // status fields
   localparam int STS_IRQ_PEND_BIT = 3;
   localparam int STS_CAP_LIST_BIT = 4;
   localparam int STS_HIGH_SPEED_BIT = 5;
   localparam int STS_B2B_BIT = 7;
   localparam int STS_POISON_BIT = 8;
   localparam int STS_SEL_TIMING_LO = 9;
   localparam int STS_SEL_TIMING_HI = 10;
   localparam int STS_TA_SIG_BIT = 11;
   localparam int STS_TA_RX_BIT = 12;
   localparam int STS_MA_RX_BIT = 13;
   // reset values
   localparam logic RST_SERR_EN = 1'b0;
   localparam logic RST_PERR_EN = 1'b0;
   localparam logic RST_IRQ_DIS = 1'b0;
   localparam logic RST_POISON = 1'b0;
   localparam logic CAP_LIST_VALUE = 1'b1;
   localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;
   localparam logic [CFG_DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- design/bcs_sticky_flag.sv ----
/*
 * write-one-to-clear sticky flags; a set in the clearing cycle wins
 * assumes set and clear are synchronous single-cycle qualifiers
 */
`default_nettype none
module bcs_sticky_flag #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clr,
   // state
   output logic [WIDTH-1:0] flag_q
);
   logic [WIDTH-1:0] flag_d;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         assign flag_d[i] = set[i] | (flag_q[i] & ~clr[i]);
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule
`default_nettype wire

// ---- design/bcs_bridge_regs.sv ----
/*
 * command bits 6 and 8-10 and status register of a bridge configuration header,
 * with error-message, legacy interrupt and poisoned-data logic
 * assumes a simple config request port; sources of events are in the core clock domain
 */
`default_nettype none
// Function
// RULE1 - report fatal/non-fatal errors when system error enable or device-control enable set
// RULE2 - back-to-back enable command bit reads zero, ignores writes
// RULE3 - read-write interrupt disable bit, reset zero, gates legacy interrupt messages
// RULE4 - interrupt pending status bit set while the device has an interrupt pending
// RULE5 - forwarded emulated interrupts from below never show in pending status
// RULE6 - downstream ports: pending follows hot-plug interrupt; upstream port reads zero
// RULE7 - capability list status bit hard-wired to one
// RULE8 - poisoned data flag set on poisoned primary TLP with parity enable; write one clears
// RULE9 - signalled target abort bit always reads zero
// RULE10 - received master abort bit read-only zero
// RULE11 - two-bit select timing field read-only zero
// RULE12 - received target abort bit read-only zero
// RULE13 - parity error response enable clear means poisoned flag never sets
// RULE14 - reserved bits read zero, ignore writes; writing zero to W1C flag changes nothing
module bcs_bridge_regs
   import bcs_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // configuration access
   input wire logic cfg_req,
   input wire logic cfg_we,
   input wire logic [bcs_pkg::CFG_ADDR_W-1:0] cfg_addr,
   input wire logic [bcs_pkg::CFG_BE_W-1:0] cfg_be,
   input wire logic [bcs_pkg::CFG_DATA_W-1:0] cfg_wdata,
   output logic cfg_ack,
   output logic [bcs_pkg::CFG_DATA_W-1:0] cfg_rdata,
   // port strap and event sources
   input wire logic port_is_upstream,
   input wire logic hotplug_irq,
   input wire logic poisoned_tlp_rx,
   input wire logic fatal_err_det,
   input wire logic nonfatal_err_det,
   input wire logic devctl_fatal_en,
   input wire logic devctl_nonfatal_en,
   // outputs to the port logic
   output logic err_fatal_msg,
   output logic err_nonfatal_msg,
   output logic intx_assert,
   output logic parity_error_response_enable,
   output logic system_error_report_enable,
   output logic legacy_irq_disable
);
   import bcs_pkg::*;

   logic rst_meta_q;
   logic rst_sync_n;
   logic strap_taken_q;
   logic upstream_q;
   logic legacy_irq_pending_q;
   logic poisoned_data_detected;
   logic hit;
   logic wr;
   logic poison_set;
   logic poison_clr;
   logic [REG_W-1:0] cmd_view;
   logic [REG_W-1:0] sts_view;

   function automatic logic lane_wr(input logic [CFG_BE_W-1:0] be, input int lane);
      return be[lane];
   endfunction

   // reset release through two flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   // access decode on the dword holding command and status
   assign hit = (cfg_addr & DWORD_MASK) == BRIDGE_COMMAND_OFS;
   assign wr = cfg_req & cfg_we & hit;

   // strap sampling window: one edge after reset release
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         strap_taken_q <= 1'b0;
      end else begin
         strap_taken_q <= 1'b1;
      end
   end

   // upstream until the strap is known, so pending stays low
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         upstream_q <= 1'b1;
      end else if (!strap_taken_q) begin
         upstream_q <= port_is_upstream;
      end
   end

   // parity response enable, lane 0; other bits of the lane ignore writes
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         parity_error_response_enable <= RST_PERR_EN;
      end else if (wr && lane_wr(cfg_be, LANE_CMD_LO)) begin
         parity_error_response_enable <= cfg_wdata[CMD_PERR_EN_BIT]; // RULE13
      end
   end

   // error report enable, lane 1
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         system_error_report_enable <= RST_SERR_EN;
      end else if (wr && lane_wr(cfg_be, LANE_CMD_HI)) begin
         system_error_report_enable <= cfg_wdata[CMD_SERR_EN_BIT]; // RULE1
      end
   end

   // interrupt disable, lane 1; back-to-back bit has no storage
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         legacy_irq_disable <= RST_IRQ_DIS; // RULE3
      end else if (wr && lane_wr(cfg_be, LANE_CMD_HI)) begin
         legacy_irq_disable <= cfg_wdata[CMD_IRQ_DIS_BIT]; // RULE3
      end
   end

   // poisoned data flag, gated by parity enable, cleared by writing one
   assign poison_set = poisoned_tlp_rx & parity_error_response_enable; // RULE8 RULE13
   assign poison_clr = wr & lane_wr(cfg_be, LANE_STS_HI)
      & cfg_wdata[REG_W + STS_POISON_BIT]; // RULE8 RULE14

   bcs_sticky_flag #(
      .WIDTH(1)
   ) u_poison (
      .clk(sys_clk),
      .rst_n(rst_sync_n),
      .set(poison_set),
      .clr(poison_clr),
      .flag_q(poisoned_data_detected)
   );

   // pending follows own hot-plug interrupt only, never forwarded ones
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         legacy_irq_pending_q <= 1'b0;
      end else begin
         legacy_irq_pending_q <= hotplug_irq & ~upstream_q & strap_taken_q; // RULE4 RULE5 RULE6
      end
   end

   // interrupt message request, masked by the disable bit
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         intx_assert <= 1'b0;
      end else begin
         intx_assert <= legacy_irq_pending_q & ~legacy_irq_disable; // RULE3
      end
   end

   // fatal message when either enable path is on
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         err_fatal_msg <= 1'b0;
      end else begin
         err_fatal_msg <= fatal_err_det & (system_error_report_enable | devctl_fatal_en); // RULE1
      end
   end

   // non-fatal message likewise
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         err_nonfatal_msg <= 1'b0;
      end else begin
         err_nonfatal_msg <= nonfatal_err_det & (system_error_report_enable | devctl_nonfatal_en); // RULE1
      end
   end

   // read views; unlisted bits stay zero
   always_comb begin
      cmd_view = REG_ZERO;
      cmd_view[CMD_PERR_EN_BIT] = parity_error_response_enable;
      cmd_view[CMD_SERR_EN_BIT] = system_error_report_enable;
      cmd_view[CMD_B2B_EN_BIT] = 1'b0; // RULE2
      cmd_view[CMD_IRQ_DIS_BIT] = legacy_irq_disable;
      sts_view = REG_ZERO; // RULE14
      sts_view[STS_IRQ_PEND_BIT] = legacy_irq_pending_q; // RULE4
      sts_view[STS_CAP_LIST_BIT] = CAP_LIST_VALUE; // RULE7
      sts_view[STS_HIGH_SPEED_BIT] = 1'b0;
      sts_view[STS_B2B_BIT] = 1'b0;
      sts_view[STS_POISON_BIT] = poisoned_data_detected; // RULE8
      sts_view[STS_SEL_TIMING_HI:STS_SEL_TIMING_LO] = 2'b00; // RULE11
      sts_view[STS_TA_SIG_BIT] = 1'b0; // RULE9
      sts_view[STS_TA_RX_BIT] = 1'b0; // RULE12
      sts_view[STS_MA_RX_BIT] = 1'b0; // RULE10
   end

   // one-cycle answer to every request; unmapped reads give zero
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cfg_ack <= 1'b0;
      end else begin
         cfg_ack <= cfg_req;
      end
   end

   // read data holds until the next request
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cfg_rdata <= DATA_ZERO;
      end else begin
         if (cfg_req && !cfg_we && hit) begin
            cfg_rdata <= {sts_view, cmd_view};
         end else if (cfg_req) begin
            cfg_rdata <= DATA_ZERO;
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/bcs_bridge_regs_sva.sv ----
/* port assertions for the command/status bank
   assumes one clock and a bind onto bcs_bridge_regs */
`default_nettype none
module bcs_regs_sva
   import bcs_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // config port
   input wire logic cfg_req,
   input wire logic cfg_we,
   input wire logic [bcs_pkg::CFG_ADDR_W-1:0] cfg_addr,
   input wire logic cfg_ack,
   input wire logic [bcs_pkg::CFG_DATA_W-1:0] cfg_rdata,
   // events and controls
   input wire logic port_is_upstream,
   input wire logic hotplug_irq,
   input wire logic fatal_err_det,
   input wire logic devctl_fatal_en,
   input wire logic err_fatal_msg,
   input wire logic intx_assert,
   input wire logic system_error_report_enable,
   input wire logic legacy_irq_disable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd; cfg_req && !cfg_we && (cfg_addr & DWORD_MASK) == BRIDGE_COMMAND_OFS; endsequence
   sequence s_irq; (!port_is_upstream && hotplug_irq && !legacy_irq_disable) [*2]; endsequence
   property p_ack; cfg_req |=> cfg_ack; endproperty
   a_ack: assert property (p_ack) else $error("missing ack");
   property p_b2b; cfg_ack |-> !cfg_rdata[CMD_B2B_EN_BIT]; endproperty
   a_b2b: assert property (p_b2b) else $error("b2b bit set");
   property p_abort; cfg_ack |-> cfg_rdata[29:25] == 5'h00; endproperty
   a_abort: assert property (p_abort) else $error("abort or timing bit set");
   property p_rsvd; cfg_ack |-> (cfg_rdata & 32'hfee7_fabf) == DATA_ZERO; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_cap; s_rd |=> cfg_rdata[STS_CAP_LIST_BIT+16]; endproperty
   a_cap: assert property (p_cap) else $error("cap bit clear");
   property p_dis; legacy_irq_disable [*2] |-> !intx_assert; endproperty
   a_dis: assert property (p_dis) else $error("irq while disabled");
   property p_pend; s_irq |=> intx_assert; endproperty
   a_pend: assert property (p_pend) else $error("hot-plug irq not raised");
   property p_up; port_is_upstream |-> !intx_assert; endproperty
   a_up: assert property (p_up) else $error("irq on upstream port");
   property p_fatal; 1'b1 |=> err_fatal_msg == $past(fatal_err_det && (system_error_report_enable || devctl_fatal_en));
   endproperty
   a_fatal: assert property (p_fatal) else $error("fatal message wrong");
endmodule
bind bcs_bridge_regs bcs_regs_sva bcs_regs_sva_inst (.*);
`default_nettype wire

// ---- test/bcs_host_model.sv ----
/* host config master, one-cycle request pulses
   assumes the bank answers one edge after each request */
`default_nettype none
module bcs_host_model
   import bcs_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // requests
   output logic cfg_req,
   output logic cfg_we,
   output logic [bcs_pkg::CFG_ADDR_W-1:0] cfg_addr,
   output logic [bcs_pkg::CFG_BE_W-1:0] cfg_be,
   output logic [bcs_pkg::CFG_DATA_W-1:0] cfg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = '0;
   task automatic acc(input logic we, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge sys_clk);
      {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = {1'b1, we, a, be, d};
      @(negedge sys_clk);
      // idle address and data lines are inverted; cfg_we and cfg_be keep the last value
      {cfg_req, cfg_addr, cfg_wdata} = {1'b0, ~a, ~d};
   endtask
endmodule
`default_nettype wire

// ---- test/bcs_bridge_regs_tb.sv ----
/* self-checking bench for the command/status bank
   assumes the checker is bound by its own file */
`default_nettype none
module bcs_bridge_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bcs_pkg::*;
   logic sys_clk = 1'b0, rst_n = 1'b0, port_is_upstream = 1'b0, hotplug_irq = 1'b0, poisoned_tlp_rx = 1'b0;
   logic fatal_err_det = 1'b0, nonfatal_err_det = 1'b0, devctl_fatal_en = 1'b0, devctl_nonfatal_en = 1'b0;
   logic cfg_req, cfg_we, cfg_ack, err_fatal_msg, err_nonfatal_msg, intx_assert;
   logic parity_error_response_enable, system_error_report_enable, legacy_irq_disable, pois_e, pend_e;
   logic [11:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, lfsr = 32'h0000_1053, exp_q[$];
   logic [15:0] cmd_e;
   int err_total = 0, checks = 0, cyc = 0;
   always #2.5 sys_clk = ~sys_clk;
   bcs_bridge_regs bcs_bridge_regs_inst (.*);
   bcs_host_model bcs_host_model_inst (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      checks++;
      if (got !== e) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, e);
      end
   endtask
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] regs_e();
      return {7'h00, pois_e, 3'h0, 1'h1, pend_e, 3'h0, cmd_e};
   endfunction
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bcs_host_model_inst.acc(1'b0, a, 4'h0, DATA_ZERO);
      chk({legacy_irq_disable, system_error_report_enable, parity_error_response_enable}, {cmd_e[10], cmd_e[8], cmd_e[6]});
   endtask
   task automatic wr(input logic [3:0] be, input logic [31:0] d);
      exp_q.push_back(DATA_ZERO);
      bcs_host_model_inst.acc(1'b1, BRIDGE_COMMAND_OFS, be, d);
      if (be[0]) cmd_e[6] = d[6];
      if (be[1]) cmd_e[10:8] = d[10:8] & 3'h5;
      if (be[3] && d[24]) pois_e = 1'b0;
   endtask
   task automatic reset_dut(input logic strap);
      rst_n = 1'b0;
      port_is_upstream = strap;
      {cmd_e, pois_e, pend_e} = '0;
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(negedge sys_clk) begin
      if (cfg_ack === 1'b1 && exp_q.size() > 0) chk(cfg_rdata, exp_q.pop_front());
      else if (cfg_ack !== 1'b0) chk({31'h0, cfg_ack}, DATA_ZERO);
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      reset_dut(1'b0);
      rd(BRIDGE_STATUS_OFS, regs_e());
      rd(12'h008, DATA_ZERO);
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         wr(lfsr[31:28], lfsr);
         rd(BRIDGE_COMMAND_OFS, regs_e());
      end
      for (int i = 0; i < 2; i++) begin
         wr(4'h1, i ? 32'h0000_0040 : DATA_ZERO);
         @(negedge sys_clk) poisoned_tlp_rx = 1'b1;
         @(negedge sys_clk) poisoned_tlp_rx = 1'b0;
         pois_e = i[0];
         rd(BRIDGE_COMMAND_OFS, regs_e());
      end
      wr(4'h8, 32'hfeff_ffff);
      rd(BRIDGE_COMMAND_OFS, regs_e());
      wr(4'h8, 32'h0100_0000);
      rd(BRIDGE_COMMAND_OFS, regs_e());
      for (int i = 0; i < 8; i++) begin
         wr(4'h2, i[0] ? 32'h0000_0100 : DATA_ZERO);
         {devctl_fatal_en, devctl_nonfatal_en} = i[2:1];
         @(negedge sys_clk) {fatal_err_det, nonfatal_err_det} = 2'b11;
         @(negedge sys_clk) {fatal_err_det, nonfatal_err_det} = 2'b00;
         chk({err_fatal_msg, err_nonfatal_msg}, {i[0] | i[2], i[0] | i[1]});
      end
      hotplug_irq = 1'b1;
      pend_e = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk(intx_assert, 1'b1);
      rd(BRIDGE_COMMAND_OFS, regs_e());
      wr(4'h2, 32'h0000_0400);
      repeat (2) @(negedge sys_clk);
      chk(intx_assert, 1'b0);
      hotplug_irq = 1'b0;
      reset_dut(1'b1);
      hotplug_irq = 1'b1;
      repeat (3) @(negedge sys_clk);
      rd(BRIDGE_COMMAND_OFS, regs_e());
      chk(intx_assert, 1'b0);
      repeat (2) @(negedge sys_clk);
      wrap_up();
   end
endmodule
`default_nettype wire
